/* logic/stk_defines.svh */
/*
 * register offsets, field positions, reset values and calibration constants of the tick timer.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef STK_DEFINES_SVH
`define STK_DEFINES_SVH

// register byte addresses
`define STK_CTRL_ADDR 32'he000e010
`define STK_RELOAD_ADDR 32'he000e014
`define STK_CURRENT_ADDR 32'he000e018
`define STK_CALIB_ADDR 32'he000e01c

// control/status field positions
`define STK_ENABLE_BIT 0
`define STK_EXC_EN_BIT 1
`define STK_CLKSEL_BIT 2
`define STK_ZERO_FLAG_BIT 16

// calibration field positions
`define STK_NO_REFERENCE_CLOCK_FLAG_BIT 31
`define STK_SKEW_BIT 30

// widths and reset values
`define STK_CNT_W 24
`define STK_CNT_RST 24'h000000
`define STK_RELOAD_RST 24'h000000
`define STK_ENABLE_RST 1'b0
`define STK_EXC_EN_RST 1'b0
`define STK_CLKSEL_RST 1'b1

// tick exception number carried with the request
`define STK_EXC_NUM 6'h0f

// ten millisecond calibration figures
`define STK_CLK_HZ 50000000
`define STK_TICK_MS 10
`define STK_TEN_MS_CYCLES ((`STK_CLK_HZ / 1000) * `STK_TICK_MS)
`define STK_TEN_MS_RELOAD 24'((`STK_TEN_MS_CYCLES) - 1)

// axi write/read responses
`define STK_RESP_OKAY 2'b00
`define STK_RESP_SLVERR 2'b10

`endif

/* logic/stk_pkg.sv */
/*
 * types shared by the tick timer files.
 * assumes stk_defines.svh is on the include path.
 */
`include "stk_defines.svh"

package stk_pkg;

	// register select decoded from a bus address
	typedef enum logic [2:0] {
		STK_SEL_CTRL,
		STK_SEL_RELOAD,
		STK_SEL_CURRENT,
		STK_SEL_CALIB,
		STK_SEL_NONE
	} stk_sel_t;

	// axi4-lite write address + data from master
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
	} stk_wr_req_t;

	// axi4-lite write answer
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
	} stk_wr_rsp_t;

	// axi4-lite read request
	typedef struct packed {
		logic arvalid;
		logic [31:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} stk_rd_req_t;

	// axi4-lite read answer
	typedef struct packed {
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} stk_rd_rsp_t;

	// exception request toward the core
	typedef struct packed {
		logic req;
		logic [5:0] num;
	} stk_exc_t;

	// state of the counting core
	typedef struct packed {
		logic [`STK_CNT_W-1:0] count;
		logic zero_flag;
		logic ref_sync1;
		logic ref_sync2;
		logic ref_last;
		logic enable_last;
		logic exc_req;
	} stk_core_st_t;

endpackage

/* logic/stk_counter.sv */
/*
 * down counter core of the tick timer: step, reload, zero flag and exception request.
 * assumes all inputs except ref_clk_in come from the clk domain; ref_clk_in is a pin.
 */
`timescale 1ns/100ps
`include "stk_defines.svh"

module stk_counter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_clk_in,
	input wire logic enable,
	input wire logic exc_enable,
	input wire logic use_cpu_clk,
	input wire logic [`STK_CNT_W-1:0] reload,
	input wire logic current_wr,
	input wire logic flag_rd_clr,
	output logic [`STK_CNT_W-1:0] count,
	output logic zero_flag,
	output logic exc_req
);
	import stk_pkg::*;

	stk_core_st_t st_r; // all state
	stk_core_st_t st_nxt; // next state
	logic step; // one counting edge this cycle

	// next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.ref_sync1 = ref_clk_in;
		st_nxt.ref_sync2 = st_r.ref_sync1;
		st_nxt.ref_last = st_r.ref_sync2;
		st_nxt.enable_last = enable;
		st_nxt.exc_req = 1'b0;
		// selected clock: every clk edge, or a rising edge of the synced reference
		step = use_cpu_clk ? 1'b1 : (st_r.ref_sync2 & ~st_r.ref_last);
		// a read clears the flag; a zero reached in the same cycle sets it again below
		if (flag_rd_clr) begin
			st_nxt.zero_flag = 1'b0;
		end
		if (current_wr) begin
			// write clears counter and flag, never requests an exception
			st_nxt.count = `STK_CNT_RST;
			st_nxt.zero_flag = 1'b0;
		end else if (enable && !st_r.enable_last) begin
			// enabling copies the reload value in
			st_nxt.count = reload;
		end else if (enable && step) begin
			if (st_r.count == `STK_CNT_W'(1)) begin
				// reached zero from counting: flag and optional request
				st_nxt.count = '0;
				st_nxt.zero_flag = 1'b1;
				st_nxt.exc_req = exc_enable;
			end else if (st_r.count == '0) begin
				// at zero the next edge reloads without software help
				st_nxt.count = reload;
			end else begin
				st_nxt.count = st_r.count - `STK_CNT_W'(1);
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count = st_r.count;
	assign zero_flag = st_r.zero_flag;
	assign exc_req = st_r.exc_req;

endmodule // stk_counter

/* logic/stk_timer.sv */
/*
 * tick timer top: axi4-lite register slave around the down counter core.
 * assumes one clock clk, an asynchronous active-low reset and a pin-level reference clock.
 */
// How it works
// - 24-bit counter counts down while enabled
// - zero reached reloads automatically and continues
// - zero can request tick exception fifteen
// - control bit 16 flags zero, read clears
// - control bit 2 picks reference or cpu clock
// - without reference, select reads one, ignores writes
// - control bit 1 gates the exception request
// - control bit 0 enables counting
// - reload value loaded on enable and zero
// - current register reads counter low bits
// - calibration field gives ten millisecond reload
// - calibration zero means value unknown
// - calibration bit 31 low means reference present
// - calibration bit 30 reports value inexactness
`timescale 1ns/100ps
`include "stk_defines.svh"

module stk_timer #(
	parameter bit HAS_REF_CLK = 1'b1, // reference clock wired in
	parameter bit CALIB_KNOWN = 1'b1 // ten millisecond value offered
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_clk_in,
	input stk_pkg::stk_wr_req_t wr_req,
	output stk_pkg::stk_wr_rsp_t wr_rsp,
	input stk_pkg::stk_rd_req_t rd_req,
	output stk_pkg::stk_rd_rsp_t rd_rsp,
	output stk_pkg::stk_exc_t exc
);
	import stk_pkg::*;

	// all bus-side state of the top
	typedef struct packed {
		logic aw_held; // write address captured
		logic [31:0] aw_addr;
		logic w_held; // write data captured
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic enable;
		logic exc_en;
		logic clk_sel;
		logic [`STK_CNT_W-1:0] reload;
		logic exc_req;
		logic awready; // registered copy of "no address held"
		logic wready; // registered copy of "no data held"
		logic arready; // registered copy of "no read answer pending"
	} stk_top_st_t;

	stk_top_st_t st_r; // registered state
	stk_top_st_t st_nxt; // next state
	logic wr_fire; // both write halves held, answer slot free
	logic rd_fire; // read address taken this cycle
	logic current_wr; // write lands on the current value register
	logic flag_rd_clr; // control register read this cycle
	logic [`STK_CNT_W-1:0] count; // counter value from the core
	logic zero_flag; // sticky zero flag from the core
	logic core_exc; // one-cycle zero event with request enabled
	logic [31:0] ctrl_rd; // control/status read image
	logic [31:0] calib_rd; // calibration read image
	logic [31:0] wmask; // byte-lane mask from write strobes
	logic [31:0] wval; // write data masked to the strobed byte lanes
	stk_sel_t wsel; // decoded write target
	stk_sel_t rsel; // decoded read target

	// address decode shared by both directions
	function automatic stk_sel_t decode(input logic [31:0] a);
		unique case (a)
			`STK_CTRL_ADDR: decode = STK_SEL_CTRL;
			`STK_RELOAD_ADDR: decode = STK_SEL_RELOAD;
			`STK_CURRENT_ADDR: decode = STK_SEL_CURRENT;
			`STK_CALIB_ADDR: decode = STK_SEL_CALIB;
			default: decode = STK_SEL_NONE;
		endcase
	endfunction

	// counting core
	stk_counter u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.ref_clk_in(ref_clk_in),
		.enable(st_r.enable),
		.exc_enable(st_r.exc_en),
		.use_cpu_clk(st_r.clk_sel),
		.reload(st_r.reload),
		.current_wr(current_wr),
		.flag_rd_clr(flag_rd_clr),
		.count(count),
		.zero_flag(zero_flag),
		.exc_req(core_exc)
	);

	// read images of the composite registers
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[`STK_ENABLE_BIT] = st_r.enable;
		ctrl_rd[`STK_EXC_EN_BIT] = st_r.exc_en;
		ctrl_rd[`STK_CLKSEL_BIT] = HAS_REF_CLK ? st_r.clk_sel : 1'b1;
		ctrl_rd[`STK_ZERO_FLAG_BIT] = zero_flag;
		calib_rd = '0;
		// zero here tells software to work the reload out itself
		calib_rd[`STK_CNT_W-1:0] = CALIB_KNOWN ? `STK_TEN_MS_RELOAD : '0;
		calib_rd[`STK_NO_REFERENCE_CLOCK_FLAG_BIT] = ~HAS_REF_CLK;
		calib_rd[`STK_SKEW_BIT] = ~CALIB_KNOWN;
	end

	// write and read path control
	always_comb begin
		wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
		wsel = decode(st_r.aw_addr);
		current_wr = wr_fire && (wsel == STK_SEL_CURRENT);
		rd_fire = rd_req.arvalid && !st_r.rvalid;
		rsel = decode(rd_req.araddr);
		flag_rd_clr = rd_fire && (rsel == STK_SEL_CTRL);
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{st_r.w_strb[i]}};
		end
		wval = st_r.w_data & wmask;
	end

	// bus and register next state
	always_comb begin
		st_nxt = st_r;
		// the exception request is a registered copy of the core pulse
		st_nxt.exc_req = core_exc;
		// accept each write half independently, one write in flight
		if (!st_r.aw_held && wr_req.awvalid) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = wr_req.awaddr;
		end
		if (!st_r.w_held && wr_req.wvalid) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = wr_req.wdata;
			st_nxt.w_strb = wr_req.wstrb;
		end
		if (wr_fire) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = `STK_RESP_OKAY;
			unique case (wsel)
				STK_SEL_CTRL: begin
					// lane 0 carries the three writable control bits
					if (st_r.w_strb[0]) begin
						st_nxt.enable = wval[`STK_ENABLE_BIT];
						st_nxt.exc_en = wval[`STK_EXC_EN_BIT];
						if (HAS_REF_CLK) begin
							st_nxt.clk_sel = wval[`STK_CLKSEL_BIT];
						end
					end
				end
				STK_SEL_RELOAD: begin
					st_nxt.reload = (st_r.reload & ~wmask[`STK_CNT_W-1:0])
						| wval[`STK_CNT_W-1:0];
				end
				STK_SEL_CURRENT: begin
					// side effect handled in the core
					st_nxt.bresp = `STK_RESP_OKAY;
				end
				STK_SEL_CALIB: begin
					// read-only: write ignored
					st_nxt.bresp = `STK_RESP_OKAY;
				end
				STK_SEL_NONE: begin
					// unmapped address answers with an error
					st_nxt.bresp = `STK_RESP_SLVERR;
				end
			endcase
		end
		if (st_r.bvalid && wr_req.bready) begin
			st_nxt.bvalid = 1'b0;
		end
		// read path: address taken in the cycle it is valid and no answer pending
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = `STK_RESP_OKAY;
			unique case (rsel)
				STK_SEL_CTRL: st_nxt.rdata = ctrl_rd;
				STK_SEL_RELOAD: st_nxt.rdata = {8'h00, st_r.reload};
				STK_SEL_CURRENT: st_nxt.rdata = {8'h00, count};
				STK_SEL_CALIB: st_nxt.rdata = calib_rd;
				STK_SEL_NONE: begin
					st_nxt.rdata = 32'h00000000;
					st_nxt.rresp = `STK_RESP_SLVERR;
				end
			endcase
		end else if (st_r.rvalid && rd_req.rready) begin
			st_nxt.rvalid = 1'b0;
		end
		// ready flags follow the next hold state so each bus output leaves a flop
		st_nxt.awready = !st_nxt.aw_held;
		st_nxt.wready = !st_nxt.w_held;
		st_nxt.arready = !st_nxt.rvalid;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.clk_sel <= `STK_CLKSEL_RST;
			st_r.reload <= `STK_RELOAD_RST;
			// nothing is held or pending, so every channel is ready
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs, all from flip-flops
	// one driver per struct: separate member assigns would double-drive the variable
	assign wr_rsp = '{awready: st_r.awready, wready: st_r.wready, bvalid: st_r.bvalid,
		bresp: st_r.bresp};
	assign rd_rsp = '{arready: st_r.arready, rvalid: st_r.rvalid, rdata: st_r.rdata,
		rresp: st_r.rresp};
	assign exc = '{req: st_r.exc_req, num: `STK_EXC_NUM};

endmodule // stk_timer

/* test/stk_core_model.sv */
/*
 * model of the core side: takes tick exception requests, makes the reference clock.
 * assumes clk at 50 MHz; ref clock runs at clk/8 while ref_run is high and stops low after ref_run falls.
 */
`timescale 1ns/100ps

module stk_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_run,
	input stk_pkg::stk_exc_t exc,
	output logic ref_clk_in,
	output logic [15:0] exc_seen,
	output logic [15:0] exc_gap,
	output logic [7:0] ref_rises
);
	import stk_pkg::*;
	logic [15:0] gap_cnt; // cycles since the last request
	logic [1:0] div; // ref clock divider

	// count requests and their spacing; the clock stops low so no stray edge appears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= 16'h0000;
			exc_seen <= 16'h0000;
			exc_gap <= 16'h0000;
			div <= 2'h0;
			ref_clk_in <= 1'b0;
			ref_rises <= 8'h00;
		end else begin
			gap_cnt <= exc.req ? 16'h0001 : gap_cnt + 16'h0001;
			if (exc.req) begin
				exc_seen <= exc_seen + 16'h0001;
				exc_gap <= gap_cnt;
			end
			div <= div + 2'h1;
			if ((ref_run || ref_clk_in) && div == 2'h3) begin
				ref_clk_in <= !ref_clk_in;
				if (!ref_clk_in) begin
					ref_rises <= ref_rises + 8'h01;
				end
			end
		end
	end
endmodule // stk_core_model

/* test/stk_timer_checker.sv */
/*
 * assertions on the tick timer's bus answers and exception request.
 * assumes it is bound into stk_timer and sees only its ports.
 */
`timescale 1ns/100ps

module stk_timer_checker #(
	parameter bit HAS_REF_CLK = 1'b1,
	parameter bit CALIB_KNOWN = 1'b1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_clk_in,
	input stk_pkg::stk_wr_req_t wr_req,
	input stk_pkg::stk_wr_rsp_t wr_rsp,
	input stk_pkg::stk_rd_req_t rd_req,
	input stk_pkg::stk_rd_rsp_t rd_rsp,
	input stk_pkg::stk_exc_t exc
);
	import stk_pkg::*;
	// calibration word the parameters call for
	localparam logic [31:0] CALIB_EXP = {~HAS_REF_CLK, ~CALIB_KNOWN, 6'h00,
		(CALIB_KNOWN ? 24'h07a11f : 24'h000000)};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// read address taken
	sequence s_rd_take;
		rd_req.arvalid && rd_rsp.arready;
	endsequence
	// both write halves taken together
	sequence s_wr_both;
		wr_req.awvalid && wr_rsp.awready && wr_req.wvalid && wr_rsp.wready;
	endsequence
	AST_EXC_NUM: assert property (exc.req |-> exc.num == 6'h0f)
		else $error("exception number wrong");
	AST_EXC_PULSE: assert property (exc.req |=> !exc.req)
		else $error("exception request longer than a pulse");
	AST_RD_ANSWER: assert property (s_rd_take |=> rd_rsp.rvalid && !rd_rsp.arready)
		else $error("read answer missing");
	AST_WR_ANSWER: assert property (s_wr_both |-> ##[1:2] wr_rsp.bvalid)
		else $error("write answer missing");
	AST_R_HOLD: assert property (rd_rsp.rvalid && !rd_req.rready |=> rd_rsp.rvalid && $stable(rd_rsp.rdata))
		else $error("read data dropped");
	AST_B_HOLD: assert property (wr_rsp.bvalid && !wr_req.bready |=> wr_rsp.bvalid && $stable(wr_rsp.bresp))
		else $error("write answer dropped");
	AST_CALIB: assert property (s_rd_take ##0 rd_req.araddr == 32'he000e01c |=> rd_rsp.rdata == CALIB_EXP)
		else $error("calibration word wrong");
	AST_CUR_HIGH: assert property (s_rd_take ##0 rd_req.araddr == 32'he000e018 |=> rd_rsp.rdata[31:24] == 8'h00)
		else $error("current value above 24 bits");
	AST_CTRL_FREE: assert property (s_rd_take ##0 rd_req.araddr == 32'he000e010 |=> rd_rsp.rdata[15:3] == 13'h0000 && rd_rsp.rdata[31:17] == 15'h0000)
		else $error("control reserved bits set");
endmodule // stk_timer_checker

bind stk_timer stk_timer_checker #(.HAS_REF_CLK(HAS_REF_CLK), .CALIB_KNOWN(CALIB_KNOWN)) u_chk (
	.clk(clk), .rst_n(rst_n), .ref_clk_in(ref_clk_in), .wr_req(wr_req), .wr_rsp(wr_rsp),
	.rd_req(rd_req), .rd_rsp(rd_rsp), .exc(exc));

/* test/tb_top.sv */
/*
 * self-checking bench of the tick timer over its axi4-lite registers.
 * assumes stk_timer, stk_core_model and the checker are compiled before it.
 */
`timescale 1ns/100ps

module tb_top;
	import stk_pkg::*;
	logic clk;
	logic rst_n;
	logic ref_run; // lets the model run the reference clock
	logic ref_clk_in;
	stk_wr_req_t wr_req;
	stk_wr_rsp_t wr_rsp;
	stk_rd_req_t rd_req;
	stk_rd_rsp_t rd_rsp;
	stk_exc_t exc;
	logic [15:0] exc_seen;
	logic [15:0] exc_gap;
	logic [7:0] ref_rises;
	logic [31:0] rd_v; // last read data
	logic [31:0] v0; // kept value
	logic [1:0] rsp; // last response code
	int n_mismatch;
	int tests_run;

	stk_timer dut (.clk(clk), .rst_n(rst_n), .ref_clk_in(ref_clk_in), .wr_req(wr_req),
		.wr_rsp(wr_rsp), .rd_req(rd_req), .rd_rsp(rd_rsp), .exc(exc));
	stk_core_model partner (.clk(clk), .rst_n(rst_n), .ref_run(ref_run), .exc(exc),
		.ref_clk_in(ref_clk_in), .exc_seen(exc_seen), .exc_gap(exc_gap), .ref_rises(ref_rises));

	// free running 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// one write; each half released when taken, handshakes seen at the negedge before the edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ta;
		logic tw;
		logic tb;
		@(posedge clk);
		wr_req.awaddr <= a;
		wr_req.wdata <= d;
		wr_req.wstrb <= 4'hf;
		wr_req.awvalid <= 1'b1;
		wr_req.wvalid <= 1'b1;
		wr_req.bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = wr_req.awvalid & wr_rsp.awready;
			tw = wr_req.wvalid & wr_rsp.wready;
			tb = wr_rsp.bvalid & wr_req.bready;
			rsp = wr_rsp.bresp;
			@(posedge clk);
			if (ta) wr_req.awvalid <= 1'b0;
			if (tw) wr_req.wvalid <= 1'b0;
			if (tb) begin
				wr_req.bready <= 1'b0;
				return;
			end
		end
		// no answer: count it, drop the request and let the main sequence report
		n_mismatch++;
		$display("FAIL write answer expected 1 seen 0");
		wr_req.awvalid <= 1'b0;
		wr_req.wvalid <= 1'b0;
		wr_req.bready <= 1'b0;
	endtask

	// one read; data and code kept in rd_v and rsp
	task automatic rd(input logic [31:0] a);
		logic ta;
		logic tr;
		@(posedge clk);
		rd_req.araddr <= a;
		rd_req.arvalid <= 1'b1;
		rd_req.rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ta = rd_req.arvalid & rd_rsp.arready;
			tr = rd_rsp.rvalid & rd_req.rready;
			rd_v = rd_rsp.rdata;
			rsp = rd_rsp.rresp;
			@(posedge clk);
			if (ta) rd_req.arvalid <= 1'b0;
			if (tr) begin
				rd_req.rready <= 1'b0;
				return;
			end
		end
		n_mismatch++;
		$display("FAIL read answer expected 1 seen 0");
		rd_req.arvalid <= 1'b0;
		rd_req.rready <= 1'b0;
	endtask

	// reset values, read-only calibration, unmapped address
	task automatic t_reset_regs;
		rd(32'he000e010);
		chk("ctrl", 32'h00000004, rd_v);
		rd(32'he000e014);
		chk("reload", 32'h00000000, rd_v);
		rd(32'he000e018);
		chk("current", 32'h00000000, rd_v);
		wr(32'he000e01c, 32'h00000000);
		chk("calib write code", 32'h00000000, {30'h0, rsp});
		rd(32'he000e01c);
		chk("calib", 32'h0007a11f, rd_v);
		rd(32'he000e020);
		chk("unmapped code", 32'h00000002, {30'h0, rsp});
		chk("unmapped data", 32'h00000000, rd_v);
		wr(32'he000e020, 32'h00000001);
		chk("unmapped write code", 32'h00000002, {30'h0, rsp});
	endtask

	// reload 5 gives a period of six steps; flag clears on read; disabled counter holds
	task automatic t_periodic;
		wr(32'he000e014, 32'h00000005);
		wr(32'he000e010, 32'h00000007);
		repeat (40) @(posedge clk);
		wr(32'he000e010, 32'h00000004);
		chk("exc gap", 32'h00000006, {16'h0, exc_gap});
		rd(32'he000e010);
		chk("flag set", 32'h00010004, rd_v);
		rd(32'he000e010);
		chk("flag cleared", 32'h00000004, rd_v);
		rd(32'he000e018);
		v0 = rd_v;
		chk("current in range", 32'h1, {31'h0, v0 <= 32'h5});
		rd(32'he000e018);
		chk("current held", v0, rd_v);
	endtask

	// zero without exception enable; then a current write clears counter and flag
	task automatic t_gate;
		v0 = {16'h0, exc_seen};
		wr(32'he000e014, 32'h00000002);
		wr(32'he000e010, 32'h00000005);
		// stop the period-three count where it has just reloaded, so the clear shows
		repeat (21) @(posedge clk);
		wr(32'he000e010, 32'h00000004);
		chk("no exception", v0, {16'h0, exc_seen});
		rd(32'he000e018);
		chk("current before clear", 32'h00000002, rd_v);
		wr(32'he000e018, 32'h00ffffff);
		rd(32'he000e018);
		chk("current cleared", 32'h00000000, rd_v);
		rd(32'he000e010);
		chk("flag cleared by write", 32'h00000004, rd_v);
	endtask

	// reference clock selected: load on enable, then one step per rising reference edge
	task automatic t_ref;
		wr(32'he000e014, 32'h00000003);
		wr(32'he000e010, 32'h00000001);
		repeat (10) @(posedge clk);
		rd(32'he000e018);
		chk("loaded", 32'h00000003, rd_v);
		rd(32'he000e010);
		chk("ref select", 32'h00000001, rd_v);
		v0 = {24'h0, ref_rises} + 32'h2;
		ref_run <= 1'b1;
		for (int n = 0; n < 100 && {24'h0, ref_rises} != v0; n++) @(posedge clk);
		if ({24'h0, ref_rises} != v0) begin
			n_mismatch++;
			$display("FAIL ref rises expected %h seen %h", v0, {24'h0, ref_rises});
		end
		ref_run <= 1'b0;
		repeat (12) @(posedge clk);
		rd(32'he000e018);
		chk("two steps", 32'h00000001, rd_v);
	endtask

	// main sequence
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		wr_req = '0;
		rd_req = '0;
		ref_run = 1'b0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_regs;
		t_periodic;
		t_gate;
		t_ref;
		complete_run;
	end
endmodule // tb_top
